// file: src/fpr_pkg.sv
// Overview of operation
// - After reset the address/fault pin is an input selecting the slave address.
// - Writing one to bit 0 of register 0x05 turns the pin into fault output.
// - In output mode the pin is 0 on any shutdown-causing fault, 1 otherwise, including during current limiting.
// - Every shutdown-causing fault drives the pin low while it is an output.
// - Latched fault bit of status register 0x02 stays set after the fault clears.
// - Latched fault bit is cleared only by a host register write.
// - High current first triggers cycle-by-cycle current limiting, not shutdown.
// - Persisting overcurrent causes shutdown with outputs high impedance.
// - After overcurrent shutdown, normal operation resumes once overcurrent is gone.
// - Overcurrent on any bridge shuts down all four half-bridges together.
// - Overtemperature enters thermal shutdown, outputs high impedance, fault low.
// - Thermal shutdown ends automatically when overtemperature clears.
// - Undervoltage on any supply forces outputs high impedance and fault low at once.
// - Power-on-reset indication clears the overload protection state.
// - Leaving shutdown ramps duty from near zero; shutdown tristates the drivers.
`default_nettype none
package fpr_pkg;

  // ==========================================================================
  // Register map (byte addresses)
  localparam logic [7:0] FPR_ADDR_STATUS = 8'h08;
  localparam logic [7:0] FPR_ADDR_CONFIG = 8'h14;
  localparam logic [7:0] FPR_ADDR_IRQ_STAT = 8'h20;
  localparam logic [7:0] FPR_ADDR_IRQ_MASK = 8'h24;
  localparam logic [7:0] FPR_ADDR_LEVELS = 8'h28;

  // ==========================================================================
  // Field positions
  localparam int FPR_BIT_FAULT_OUT_EN = 0;
  localparam int FPR_BIT_LATCHED_FAULT = 1;
  localparam int FPR_IRQ_W = 4;
  localparam int FPR_IRQ_OC = 0;
  localparam int FPR_IRQ_OT = 1;
  localparam int FPR_IRQ_UV = 2;
  localparam int FPR_IRQ_OCSD = 3;

  // ==========================================================================
  // Timing: overcurrent persistence and soft-start ramp
  localparam int FPR_CLK_NS = 40;
  localparam int FPR_OC_PERSIST_NS = 10000;
  localparam int FPR_OC_PERSIST_CYC = (FPR_OC_PERSIST_NS + FPR_CLK_NS - 1) / FPR_CLK_NS;
  localparam int FPR_CNT_W = 12;
  localparam int FPR_DUTY_W = 8;
  localparam logic [FPR_DUTY_W-1:0] FPR_DUTY_MIN = 8'h01;
  localparam logic [FPR_DUTY_W-1:0] FPR_DUTY_DEF = 8'h80;
  localparam logic [FPR_DUTY_W-1:0] FPR_RAMP_DIV = 8'h03;

  localparam logic [1:0] FPR_RESP_OKAY = 2'h0;
  localparam logic [1:0] FPR_RESP_SLVERR = 2'h2;

  // Protection state, one-hot
  typedef enum logic [3:0] {
    FPR_RUN = 4'b0001,
    FPR_LIMIT = 4'b0010,
    FPR_SHUT = 4'b0100,
    FPR_RAMP = 4'b1000
  } fpr_state_t;

  // Synchronised detector group
  typedef struct packed {
    logic oc;
    logic ot;
    logic uv;
    logic por;
  } fpr_det_t;

endpackage : fpr_pkg
`default_nettype wire

// file: src/fpr_fault_protect.sv
`timescale 1ns/10ps
`default_nettype none
module fpr_fault_protect (
  // Clock and reset
  input wire logic aclk,
  input wire logic aresetn,
  // AXI4-Lite write address
  input wire logic [7:0] s_axi_awaddr,
  input wire logic s_axi_awvalid,
  output logic s_axi_awready,
  // AXI4-Lite write data
  input wire logic [31:0] s_axi_wdata,
  input wire logic [3:0] s_axi_wstrb,
  input wire logic s_axi_wvalid,
  output logic s_axi_wready,
  // AXI4-Lite write response
  output logic [1:0] s_axi_bresp,
  output logic s_axi_bvalid,
  input wire logic s_axi_bready,
  // AXI4-Lite read address
  input wire logic [7:0] s_axi_araddr,
  input wire logic s_axi_arvalid,
  output logic s_axi_arready,
  // AXI4-Lite read data
  output logic [31:0] s_axi_rdata,
  output logic [1:0] s_axi_rresp,
  output logic s_axi_rvalid,
  input wire logic s_axi_rready,
  // Analog detectors (asynchronous)
  input wire logic [3:0] overcurrent_error,
  input wire logic overtemp_error,
  input wire logic undervoltage_error,
  input wire logic por_active,
  // Address-select / fault pin
  input wire logic addr_fault_i,
  output logic addr_fault_o,
  output logic addr_fault_oe,
  output logic addr_select_q,
  // Power stage
  output logic [3:0] bridge_hiz,
  output logic current_limit,
  output logic [7:0] duty_limit,
  // Interrupt
  output logic irq
);

  // ==========================================================================
  // Detector synchronisers
  logic [6:0] sync1_q;
  logic [6:0] sync2_q;
  logic [6:0] det_raw;
  fpr_pkg::fpr_det_t det;
  logic oc_any;

  assign det_raw = {overcurrent_error, overtemp_error, undervoltage_error, por_active};

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      sync1_q <= 7'h00;
      sync2_q <= 7'h00;
    end else begin
      sync1_q <= det_raw;
      sync2_q <= sync1_q;
    end
  end

  assign oc_any = |sync2_q[6:3];
  assign det = '{oc: oc_any, ot: sync2_q[2], uv: sync2_q[1], por: sync2_q[0]};

  // ==========================================================================
  // Protection state machine
  fpr_pkg::fpr_state_t state_q;
  logic [fpr_pkg::FPR_CNT_W-1:0] oc_cnt_q;
  logic [fpr_pkg::FPR_DUTY_W-1:0] duty_q;
  logic [fpr_pkg::FPR_DUTY_W-1:0] ramp_div_q;
  logic [fpr_pkg::FPR_DUTY_W-1:0] duty_target_q;
  logic oc_persist;
  logic shut_cause;
  logic fault_now;

  assign oc_persist = (oc_cnt_q == fpr_pkg::FPR_CNT_W'(fpr_pkg::FPR_OC_PERSIST_CYC - 1));
  assign shut_cause = det.ot || det.uv;

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      state_q <= fpr_pkg::FPR_RUN;
      oc_cnt_q <= '0;
    end else if (det.por) begin
      state_q <= fpr_pkg::FPR_SHUT;
      oc_cnt_q <= '0;
    end else begin
      case (state_q)
        fpr_pkg::FPR_RUN, fpr_pkg::FPR_RAMP: begin
          oc_cnt_q <= '0;
          if (shut_cause) begin
            state_q <= fpr_pkg::FPR_SHUT;
          end else if (det.oc) begin
            state_q <= fpr_pkg::FPR_LIMIT;
          end else if (state_q == fpr_pkg::FPR_RAMP && duty_q >= duty_target_q) begin
            state_q <= fpr_pkg::FPR_RUN;
          end
        end
        fpr_pkg::FPR_LIMIT: begin
          if (shut_cause) begin
            state_q <= fpr_pkg::FPR_SHUT;
          end else if (!det.oc) begin
            state_q <= fpr_pkg::FPR_RUN;
          end else if (oc_persist) begin
            state_q <= fpr_pkg::FPR_SHUT;
          end else begin
            oc_cnt_q <= oc_cnt_q + 1'b1;
          end
        end
        fpr_pkg::FPR_SHUT: begin
          oc_cnt_q <= '0;
          if (!shut_cause && !det.oc) begin
            state_q <= fpr_pkg::FPR_RAMP;
          end
        end
        default: begin
          state_q <= fpr_pkg::FPR_SHUT;
        end
      endcase
    end
  end

  // ==========================================================================
  // Soft-start ramp
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      duty_q <= fpr_pkg::FPR_DUTY_MIN;
      ramp_div_q <= '0;
    end else if (state_q == fpr_pkg::FPR_SHUT) begin
      duty_q <= fpr_pkg::FPR_DUTY_MIN;
      ramp_div_q <= '0;
    end else if (state_q == fpr_pkg::FPR_RAMP) begin
      if (ramp_div_q == fpr_pkg::FPR_RAMP_DIV) begin
        ramp_div_q <= '0;
        if (duty_q < duty_target_q) begin
          duty_q <= duty_q + 1'b1;
        end
      end else begin
        ramp_div_q <= ramp_div_q + 1'b1;
      end
    end else begin
      duty_q <= duty_target_q;
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      bridge_hiz <= 4'hf;
      current_limit <= 1'b0;
      duty_limit <= 8'h00;
    end else begin
      bridge_hiz <= {4{state_q == fpr_pkg::FPR_SHUT || shut_cause}};
      current_limit <= (state_q == fpr_pkg::FPR_LIMIT);
      duty_limit <= (state_q == fpr_pkg::FPR_SHUT) ? 8'h00 : duty_q;
    end
  end

  // ==========================================================================
  // Fault pin and address strap
  logic fault_out_en_q;
  logic strap_taken_q;

  assign fault_now = (state_q == fpr_pkg::FPR_SHUT) || shut_cause;

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      strap_taken_q <= 1'b0;
      addr_select_q <= 1'b0;
    end else if (!strap_taken_q) begin
      strap_taken_q <= 1'b1;
      addr_select_q <= addr_fault_i;
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      addr_fault_oe <= 1'b0;
      addr_fault_o <= 1'b1;
    end else begin
      addr_fault_oe <= fault_out_en_q;
      addr_fault_o <= !fault_now;
    end
  end

  // ==========================================================================
  // AXI4-Lite slave
  logic aw_hold_q;
  logic w_hold_q;
  logic [7:0] awaddr_q;
  logic [31:0] wdata_q;
  logic [3:0] wstrb_q;
  logic wr_fire;
  logic latched_fault_q;
  logic [fpr_pkg::FPR_IRQ_W-1:0] irq_stat_q;
  logic [fpr_pkg::FPR_IRQ_W-1:0] irq_mask_q;
  logic [fpr_pkg::FPR_IRQ_W-1:0] irq_evt;
  logic [2:0] prev_q;
  logic oc_sd_evt;
  logic prev_shut_q;
  logic [31:0] rd_val;
  logic rd_ok;

  assign s_axi_awready = !aw_hold_q && !s_axi_bvalid;
  assign s_axi_wready = !w_hold_q && !s_axi_bvalid;
  assign s_axi_arready = !s_axi_rvalid;
  assign wr_fire = aw_hold_q && w_hold_q && !s_axi_bvalid;

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      aw_hold_q <= 1'b0;
      w_hold_q <= 1'b0;
      awaddr_q <= 8'h00;
      wdata_q <= 32'h0000_0000;
      wstrb_q <= 4'h0;
      s_axi_bvalid <= 1'b0;
      s_axi_bresp <= fpr_pkg::FPR_RESP_OKAY;
    end else begin
      if (s_axi_awvalid && s_axi_awready) begin
        aw_hold_q <= 1'b1;
        awaddr_q <= s_axi_awaddr;
      end
      if (s_axi_wvalid && s_axi_wready) begin
        w_hold_q <= 1'b1;
        wdata_q <= s_axi_wdata;
        wstrb_q <= s_axi_wstrb;
      end
      if (wr_fire) begin
        aw_hold_q <= 1'b0;
        w_hold_q <= 1'b0;
        s_axi_bvalid <= 1'b1;
        case (awaddr_q)
          fpr_pkg::FPR_ADDR_STATUS, fpr_pkg::FPR_ADDR_CONFIG, fpr_pkg::FPR_ADDR_IRQ_STAT,
          fpr_pkg::FPR_ADDR_IRQ_MASK, fpr_pkg::FPR_ADDR_LEVELS: begin
            s_axi_bresp <= fpr_pkg::FPR_RESP_OKAY;
          end
          default: begin
            s_axi_bresp <= fpr_pkg::FPR_RESP_SLVERR;
          end
        endcase
      end else if (s_axi_bvalid && s_axi_bready) begin
        s_axi_bvalid <= 1'b0;
      end
    end
  end

  // Control register: fault pin mode and duty target
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      fault_out_en_q <= 1'b0;
      duty_target_q <= fpr_pkg::FPR_DUTY_DEF;
    end else if (wr_fire && awaddr_q == fpr_pkg::FPR_ADDR_CONFIG) begin
      if (wstrb_q[0]) begin
        fault_out_en_q <= wdata_q[fpr_pkg::FPR_BIT_FAULT_OUT_EN];
      end
      if (wstrb_q[1]) begin
        duty_target_q <= wdata_q[15:8];
      end
    end
  end

  // Latched fault bit: set wins over clear, cleared only by a write of one
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      latched_fault_q <= 1'b0;
    end else if (fault_now) begin
      latched_fault_q <= 1'b1;
    end else if (wr_fire && awaddr_q == fpr_pkg::FPR_ADDR_STATUS && wstrb_q[0]
                 && wdata_q[fpr_pkg::FPR_BIT_LATCHED_FAULT]) begin
      latched_fault_q <= 1'b0;
    end
  end

  // Interrupt events
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      prev_q <= 3'h0;
      prev_shut_q <= 1'b0;
    end else begin
      prev_q <= {det.oc, det.ot, det.uv};
      prev_shut_q <= (state_q == fpr_pkg::FPR_SHUT) && det.oc;
    end
  end

  assign oc_sd_evt = (state_q == fpr_pkg::FPR_SHUT) && det.oc && !prev_shut_q;
  assign irq_evt = {oc_sd_evt, det.uv && !prev_q[0], det.ot && !prev_q[1], det.oc && !prev_q[2]};

  genvar gi;
  generate
    for (gi = 0; gi < fpr_pkg::FPR_IRQ_W; gi++) begin : g_irq
      always_ff @(posedge aclk) begin
        if (!aresetn) begin
          irq_stat_q[gi] <= 1'b0;
        end else if (irq_evt[gi]) begin
          irq_stat_q[gi] <= 1'b1;
        end else if (wr_fire && awaddr_q == fpr_pkg::FPR_ADDR_IRQ_STAT && wstrb_q[0]
                     && wdata_q[gi]) begin
          irq_stat_q[gi] <= 1'b0;
        end
      end
    end
  endgenerate

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      irq_mask_q <= '0;
    end else if (wr_fire && awaddr_q == fpr_pkg::FPR_ADDR_IRQ_MASK && wstrb_q[0]) begin
      irq_mask_q <= wdata_q[fpr_pkg::FPR_IRQ_W-1:0];
    end
  end

  assign irq = |(irq_stat_q & irq_mask_q);

  // Read path
  always_comb begin
    rd_val = 32'h0000_0000;
    rd_ok = 1'b1;
    case (s_axi_araddr)
      fpr_pkg::FPR_ADDR_STATUS: rd_val[fpr_pkg::FPR_BIT_LATCHED_FAULT] = latched_fault_q;
      fpr_pkg::FPR_ADDR_CONFIG: rd_val = {16'h0000, duty_target_q, 7'h00, fault_out_en_q};
      fpr_pkg::FPR_ADDR_IRQ_STAT: rd_val = {28'h0000000, irq_stat_q};
      fpr_pkg::FPR_ADDR_IRQ_MASK: rd_val = {28'h0000000, irq_mask_q};
      fpr_pkg::FPR_ADDR_LEVELS: rd_val = {20'h00000, duty_q, state_q};
      default: rd_ok = 1'b0;
    endcase
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      s_axi_rvalid <= 1'b0;
      s_axi_rdata <= 32'h0000_0000;
      s_axi_rresp <= fpr_pkg::FPR_RESP_OKAY;
    end else if (s_axi_arvalid && s_axi_arready) begin
      s_axi_rvalid <= 1'b1;
      s_axi_rdata <= rd_val;
      s_axi_rresp <= rd_ok ? fpr_pkg::FPR_RESP_OKAY : fpr_pkg::FPR_RESP_SLVERR;
    end else if (s_axi_rvalid && s_axi_rready) begin
      s_axi_rvalid <= 1'b0;
    end
  end

  // ==========================================================================
  // Assertions
  default clocking cb @(posedge aclk); endclocking
  default disable iff (!aresetn);

  AST_SYNC_DELAY: assert property ($rose(overtemp_error) && !det.por ##0 overtemp_error [*3]
    |-> det.ot) else $error("overtemp not seen after two stages");
  AST_OT_HIZ: assert property (det.ot |=> bridge_hiz == 4'hf) else $error("ot without hiz");
  AST_UV_HIZ: assert property (det.uv |=> bridge_hiz == 4'hf) else $error("uv without hiz");
  AST_FAULT_PIN: assert property (fault_now |=> !addr_fault_o) else $error("pin not low");
  AST_PIN_MODE: assert property (!$past(fault_out_en_q) |-> !addr_fault_oe)
    else $error("pin driven while input");
  AST_LATCH_HOLD: assert property (latched_fault_q && !(wr_fire &&
    awaddr_q == fpr_pkg::FPR_ADDR_STATUS) |=> latched_fault_q) else $error("latch lost");
  AST_LATCH_SET: assert property (fault_now |=> latched_fault_q) else $error("latch not set");
  AST_LIMIT_FIRST: assert property (state_q == fpr_pkg::FPR_RUN && det.oc && !shut_cause
    && !det.por |=> state_q == fpr_pkg::FPR_LIMIT) else $error("no limit step");
  AST_OC_ALL: assert property (state_q == fpr_pkg::FPR_SHUT |=> bridge_hiz == 4'hf)
    else $error("partial shutdown");
  AST_RESUME: assert property (state_q == fpr_pkg::FPR_SHUT && !det.oc && !shut_cause
    && !det.por |=> state_q == fpr_pkg::FPR_RAMP) else $error("no resume");
  AST_POR: assert property (det.por |=> state_q == fpr_pkg::FPR_SHUT && oc_cnt_q == '0)
    else $error("por did not clear");
  AST_RAMP_START: assert property (state_q == fpr_pkg::FPR_SHUT ##1
    state_q == fpr_pkg::FPR_RAMP |-> duty_q == fpr_pkg::FPR_DUTY_MIN)
    else $error("ramp not from minimum");

  COV_LIMIT: cover property (state_q == fpr_pkg::FPR_LIMIT ##1 state_q == fpr_pkg::FPR_RUN);
  COV_OC_SHUT: cover property (state_q == fpr_pkg::FPR_LIMIT ##1 state_q == fpr_pkg::FPR_SHUT);
  COV_RAMP_DONE: cover property (state_q == fpr_pkg::FPR_RAMP ##1 state_q == fpr_pkg::FPR_RUN);
  COV_FAULT_OUT: cover property (addr_fault_oe && !addr_fault_o);

endmodule // fpr_fault_protect
`default_nettype wire

// file: verification/fpr_host_model.sv
`timescale 1ns/10ps
`default_nettype none
// ============================================================
// Host side of the address-select / fault pin
module fpr_host_model #(
  parameter logic STRAP = 1'b1
) (
  // Pin as seen from the device
  input wire logic pin_o,
  input wire logic pin_oe,
  // Resolved wire level
  output logic pin_level
);
  // Pull-up strap while released, device level while driven
  assign pin_level = pin_oe ? pin_o : STRAP;
endmodule // fpr_host_model
`default_nettype wire

// file: verification/tb_top.sv
`timescale 1ns/10ps
`default_nettype none
`define CHK(a, b) begin total_checks++; if ((a) !== (b)) begin n_errors++; \
  $display("ERROR %0t: mismatch got %h exp %h", $time, (a), (b)); end end
module tb_top;
  logic aclk = 1'b0;
  logic aresetn = 1'b0;
  logic [7:0] awaddr = 8'h00, araddr = 8'h00;
  logic awvalid = 1'b0, wvalid = 1'b0, bready = 1'b0, arvalid = 1'b0, rready = 1'b0;
  logic [31:0] wdata = 32'h0;
  logic [3:0] wstrb = 4'h0;
  logic awready, wready, bvalid, arready, rvalid;
  logic [1:0] bresp, rresp, resp;
  logic [31:0] rdata, rd;
  logic [3:0] oc = 4'h0;
  logic ot = 1'b0, uv = 1'b0, por = 1'b0;
  logic pin_lvl, pin_o, pin_oe, addr_sel, cur_lim, irq;
  logic [3:0] hiz;
  logic [7:0] duty;
  int n_errors = 0;
  int total_checks = 0;
  int cyc = 0;

  always #20 aclk = ~aclk;

  fpr_fault_protect dut (
    .aclk(aclk), .aresetn(aresetn),
    .s_axi_awaddr(awaddr), .s_axi_awvalid(awvalid), .s_axi_awready(awready),
    .s_axi_wdata(wdata), .s_axi_wstrb(wstrb), .s_axi_wvalid(wvalid), .s_axi_wready(wready),
    .s_axi_bresp(bresp), .s_axi_bvalid(bvalid), .s_axi_bready(bready),
    .s_axi_araddr(araddr), .s_axi_arvalid(arvalid), .s_axi_arready(arready),
    .s_axi_rdata(rdata), .s_axi_rresp(rresp), .s_axi_rvalid(rvalid), .s_axi_rready(rready),
    .overcurrent_error(oc), .overtemp_error(ot), .undervoltage_error(uv), .por_active(por),
    .addr_fault_i(pin_lvl), .addr_fault_o(pin_o), .addr_fault_oe(pin_oe),
    .addr_select_q(addr_sel), .bridge_hiz(hiz), .current_limit(cur_lim),
    .duty_limit(duty), .irq(irq)
  );

  fpr_host_model #(.STRAP(1'b1)) host (.pin_o(pin_o), .pin_oe(pin_oe), .pin_level(pin_lvl));

  // ============================================================
  // Bus cycles
  task automatic axi_wr(input logic [7:0] a, input logic [31:0] d);
    @(posedge aclk);
    awaddr <= a; awvalid <= 1'b1; wdata <= d; wstrb <= 4'hf; wvalid <= 1'b1; bready <= 1'b1;
    do begin
      @(posedge aclk);
      if (awvalid && awready) awvalid <= 1'b0;
      if (wvalid && wready) wvalid <= 1'b0;
    end while (!(bvalid && bready));
    resp = bresp;
    bready <= 1'b0;
  endtask

  task automatic axi_rd(input logic [7:0] a);
    @(posedge aclk);
    araddr <= a; arvalid <= 1'b1; rready <= 1'b1;
    do begin
      @(posedge aclk);
      if (arvalid && arready) arvalid <= 1'b0;
    end while (!(rvalid && rready));
    rd = rdata;
    resp = rresp;
    rready <= 1'b0;
  endtask

  task automatic tick(input int n);
    repeat (n) @(posedge aclk);
    #1;
  endtask

  task automatic wait_run();
    int n;
    n = 0;
    while (hiz !== 4'h0 && n < 300) begin
      tick(1);
      n++;
    end
  endtask

  // ============================================================
  // Scenarios
  task automatic t_reset_and_enable();
    `CHK(addr_sel, 1'b1)
    `CHK(pin_oe, 1'b0)
    axi_rd(fpr_pkg::FPR_ADDR_STATUS);
    `CHK(rd[fpr_pkg::FPR_BIT_LATCHED_FAULT], 1'b0)
    axi_rd(8'h3c);
    `CHK(resp, fpr_pkg::FPR_RESP_SLVERR)
    axi_wr(fpr_pkg::FPR_ADDR_CONFIG, 32'h0000_8001);
    `CHK(resp, fpr_pkg::FPR_RESP_OKAY)
    tick(2);
    `CHK(pin_oe, 1'b1)
    `CHK(pin_lvl, 1'b1)
    axi_wr(fpr_pkg::FPR_ADDR_IRQ_MASK, 32'h0000_000f);
    tick(600);
    `CHK(duty, fpr_pkg::FPR_DUTY_DEF)
    axi_rd(fpr_pkg::FPR_ADDR_LEVELS);
    `CHK(rd[3:0], fpr_pkg::FPR_RUN)
    `CHK(rd[11:4], fpr_pkg::FPR_DUTY_DEF)
  endtask

  task automatic t_overtemp();
    @(posedge aclk);
    ot <= 1'b1;
    tick(1);
    `CHK(hiz, 4'h0)
    tick(4);
    `CHK(hiz, 4'hf)
    `CHK(pin_lvl, 1'b0)
    `CHK(duty, 8'h00)
    `CHK(irq, 1'b1)
    @(posedge aclk);
    ot <= 1'b0;
    wait_run();
    `CHK(hiz, 4'h0)
    `CHK(duty <= 8'h02, 1'b1)
    `CHK(pin_lvl, 1'b1)
    tick(600);
    `CHK(duty, fpr_pkg::FPR_DUTY_DEF)
    axi_rd(fpr_pkg::FPR_ADDR_STATUS);
    `CHK(rd[fpr_pkg::FPR_BIT_LATCHED_FAULT], 1'b1)
    axi_rd(fpr_pkg::FPR_ADDR_STATUS);
    `CHK(rd[fpr_pkg::FPR_BIT_LATCHED_FAULT], 1'b1)
    axi_wr(fpr_pkg::FPR_ADDR_STATUS, 32'h0000_0002);
    axi_rd(fpr_pkg::FPR_ADDR_STATUS);
    `CHK(rd[fpr_pkg::FPR_BIT_LATCHED_FAULT], 1'b0)
    axi_rd(fpr_pkg::FPR_ADDR_IRQ_STAT);
    `CHK(rd[fpr_pkg::FPR_IRQ_OT], 1'b1)
    axi_wr(fpr_pkg::FPR_ADDR_IRQ_STAT, 32'h0000_000f);
    tick(1);
    `CHK(irq, 1'b0)
  endtask

  task automatic t_undervolt_masked();
    axi_wr(fpr_pkg::FPR_ADDR_IRQ_MASK, 32'h0000_0000);
    @(posedge aclk);
    uv <= 1'b1;
    tick(4);
    `CHK(hiz, 4'hf)
    `CHK(pin_lvl, 1'b0)
    `CHK(irq, 1'b0)
    @(posedge aclk);
    uv <= 1'b0;
    wait_run();
    `CHK(hiz, 4'h0)
    axi_rd(fpr_pkg::FPR_ADDR_IRQ_STAT);
    `CHK(rd[fpr_pkg::FPR_IRQ_UV], 1'b1)
    axi_wr(fpr_pkg::FPR_ADDR_IRQ_STAT, 32'h0000_000f);
    axi_wr(fpr_pkg::FPR_ADDR_STATUS, 32'h0000_0002);
  endtask

  task automatic t_overcurrent();
    @(posedge aclk);
    oc <= 4'b1000;
    tick(4);
    `CHK(cur_lim, 1'b1)
    @(posedge aclk);
    oc <= 4'b0000;
    tick(5);
    `CHK(cur_lim, 1'b0)
    `CHK(hiz, 4'h0)
    @(posedge aclk);
    oc <= 4'b0100;
    tick(4);
    `CHK(cur_lim, 1'b1)
    `CHK(hiz, 4'h0)
    tick(fpr_pkg::FPR_OC_PERSIST_CYC + 8);
    `CHK(hiz, 4'hf)
    `CHK(pin_lvl, 1'b0)
    @(posedge aclk);
    oc <= 4'b0000;
    wait_run();
    `CHK(hiz, 4'h0)
    `CHK(cur_lim, 1'b0)
    axi_rd(fpr_pkg::FPR_ADDR_STATUS);
    `CHK(rd[fpr_pkg::FPR_BIT_LATCHED_FAULT], 1'b1)
    axi_rd(fpr_pkg::FPR_ADDR_IRQ_STAT);
    `CHK(rd[fpr_pkg::FPR_IRQ_OC], 1'b1)
    `CHK(rd[fpr_pkg::FPR_IRQ_OCSD], 1'b1)
  endtask

  task automatic t_por();
    @(posedge aclk);
    oc <= 4'b0001;
    tick(20);
    @(posedge aclk);
    por <= 1'b1;
    tick(4);
    `CHK(hiz, 4'hf)
    @(posedge aclk);
    oc <= 4'b0000;
    tick(1);
    @(posedge aclk);
    por <= 1'b0;
    wait_run();
    `CHK(hiz, 4'h0)
    `CHK(cur_lim, 1'b0)
  endtask

  // ============================================================
  // Verdict
  task automatic close_out();
    $display("Checks %0d, errors %0d", total_checks, n_errors);
    if (n_errors == 0 && total_checks > 0) begin
      $display("Run complete: PASS");
    end else begin
      $display("Run complete: FAIL");
    end
    $finish;
  endtask

  always @(posedge aclk) begin
    cyc <= cyc + 1;
    if (cyc == 20000) begin
      n_errors++;
      close_out();
    end
  end

  initial begin
    repeat (20) @(posedge aclk);
    aresetn <= 1'b1;
    tick(2);
    t_reset_and_enable();
    t_overtemp();
    t_undervolt_masked();
    t_overcurrent();
    t_por();
    close_out();
  end
endmodule // tb_top
`default_nettype wire
